// File: testbench.sv
// Testbench of the vectored priority interrupt controller.
`timescale 1ns/1ps
`include "vpi_cfg.svh"
// ==========================================================================
// Bench
// ==========================================================================
module testbench;
   localparam logic [5:0] C1 = `VPI_IDX_CTRL1;
   localparam logic [5:0] C2 = `VPI_IDX_CTRL2;
   localparam logic [5:0] F0 = `VPI_IDX_FLAG0;
   localparam logic [5:0] E0 = `VPI_IDX_EN0;
   localparam logic [5:0] P0 = `VPI_IDX_PRIO0;
   localparam logic [5:0] CA = `VPI_IDX_CAPTURE;
   localparam logic [5:0] ST = `VPI_IDX_STATUS;
   localparam logic [5:0] CO = `VPI_IDX_CORE;
   logic              hclk = 1'b0;
   logic              hresetn = 1'b0;
   logic              hsel = 1'b0;
   logic [31:0]       haddr = 32'h0;
   logic [1:0]        htrans = 2'h0;
   logic              hwrite = 1'b0;
   logic [31:0]       hwdata = 32'h0;
   vpi_pkg::vpi_src_t src_req = '0;
   logic [4:0]        ext_req = 5'h0;
   logic [3:0]        trap_event = 4'h0;
   logic              ack_en = 1'b0;
   logic              hready, hresp, irq, irq_ack, isr_exit;
   logic [31:0]       hrdata, rdv;
   logic [6:0]        irq_vector;
   logic [3:0]        irq_level, restore_level;
   logic [23:0]       irq_address;
   int                bad_count = 0;
   int                n_checks = 0;
   int                cycles = 0;
   vpi_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready, .hreadyout(hready), .hresp, .hrdata, .src_req, .ext_req, .trap_event,
      .irq_ack, .isr_exit, .restore_level, .irq, .irq_vector, .irq_level, .irq_address);
   vpi_core_model core (.hclk, .hresetn, .irq, .ack_en, .lag(4'hC), .entry_level(4'h0),
      .irq_ack, .isr_exit, .restore_level);
   always #10 hclk = ~hclk;
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (bad_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic [5:0] idx, input logic wr, input logic [15:0] wd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, idx, 2'b00};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0, wd};
      do @(posedge hclk); while (hready !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
      bus(idx, 1'b0, 16'h0);
      chk(rdv, exp);
   endtask
   task automatic pulse(input vpi_pkg::vpi_src_t m);
      src_req <= m;
      @(posedge hclk);
      src_req <= '0;
      @(posedge hclk);
   endtask
   task automatic see(input logic on, input logic [6:0] v, input logic [3:0] l,
                      input logic [23:0] a);
      repeat (3) @(negedge hclk);
      chk({31'h0, irq}, {31'h0, on});
      if (on) begin
         chk({25'h0, irq_vector}, {25'h0, v});
         chk({28'h0, irq_level}, {28'h0, l});
         chk({8'h0, irq_address}, {8'h0, a});
      end
      @(posedge hclk);
   endtask
   task automatic t_reset();
      rchk(ST, 32'h0);
      rchk(CO, 32'h4);
      rchk(C2, 32'h0);
      bus(6'h1C, 1'b1, 16'hFFFF);
      rchk(6'h1C, 32'h0);
      bus(CO, 1'b1, 16'hFFFF);
      rchk(CO, 32'h4);
   endtask
   task automatic t_ext();
      ext_req <= 5'h1F;
      @(posedge hclk);
      rchk(F0, 32'h1);
      rchk(F0 + 6'h1, 32'h2010);
      rchk(F0 + 6'h3, 32'h60);
      bus(F0, 1'b1, 16'h0);
      ext_req <= 5'h0;
      @(posedge hclk);
      rchk(F0, 32'h0);
      bus(C2, 1'b1, 16'h001F);
      ext_req <= 5'h1F;
      @(posedge hclk);
      rchk(F0, 32'h0);
      ext_req <= 5'h0;
      @(posedge hclk);
      rchk(F0, 32'h1);
      rchk(C2, 32'h1F);
      bus(C2, 1'b1, 16'h0);
      bus(F0, 1'b1, 16'h0);
   endtask
   task automatic t_basic();
      bus(E0, 1'b1, 16'h0008);
      bus(P0, 1'b1, 16'h4000);
      pulse(96'h8);
      see(1'b1, 7'h03, 4'h4, 24'h1A);
      rchk(F0, 32'h8);
      rchk(CA, 32'h0403);
      ack_en <= 1'b1;
      while (irq_ack !== 1'b1) @(posedge hclk);
      ack_en <= 1'b0;
      rchk(ST, 32'h80);
      bus(F0, 1'b1, 16'h0);
      while (isr_exit !== 1'b1) @(posedge hclk);
      rchk(ST, 32'h0);
      see(1'b0, 7'h0, 4'h0, 24'h0);
   endtask
   task automatic t_arb();
      bus(P0, 1'b1, 16'h0);
      bus(P0 + 6'h1, 1'b1, 16'h5000);
      bus(P0 + 6'h2, 1'b1, 16'h6006);
      bus(P0 + 6'h3, 1'b1, 16'h0002);
      bus(E0, 1'b1, 16'h1908);
      pulse(96'h88);
      see(1'b0, 7'h0, 4'h0, 24'h0);
      pulse(96'h1900);
      see(1'b1, 7'h08, 4'h6, 24'h24);
      bus(E0, 1'b1, 16'h1808);
      see(1'b1, 7'h0B, 4'h6, 24'h2A);
   endtask
   task automatic t_level();
      bus(ST, 1'b1, 16'h00C0);
      see(1'b0, 7'h0, 4'h0, 24'h0);
      bus(ST, 1'b1, 16'h00A0);
      see(1'b1, 7'h0B, 4'h6, 24'h2A);
      bus(P0 + 6'h2, 1'b1, 16'h7006);
      bus(ST, 1'b1, 16'h00E0);
      see(1'b0, 7'h0, 4'h0, 24'h0);
      bus(C1, 1'b1, 16'h8000);
      bus(ST, 1'b1, 16'h0020);
      rchk(ST, 32'hE0);
      bus(C1, 1'b1, 16'h0);
      bus(ST, 1'b1, 16'hFF1F);
      rchk(ST, 32'h0);
      bus(C2, 1'b1, 16'h8000);
      see(1'b1, 7'h0B, 4'h7, 24'h12A);
      bus(C2, 1'b1, 16'h0);
   endtask
   task automatic t_trap();
      trap_event <= 4'h9;
      @(posedge hclk);
      trap_event <= 4'h0;
      rchk(C1, 32'h12);
      rchk(CO, 32'hC);
      see(1'b0, 7'h0, 4'h0, 24'h0);
      bus(CO, 1'b1, 16'h0);
      rchk(CO, 32'h4);
      see(1'b1, 7'h0B, 4'h7, 24'h2A);
   endtask
   task automatic t_nest();
      bus(C1, 1'b1, 16'h8000);
      bus(E0, 1'b1, 16'h1008);
      see(1'b1, 7'h0C, 4'h2, 24'h2C);
      ack_en <= 1'b1;
      while (irq_ack !== 1'b1) @(posedge hclk);
      ack_en <= 1'b0;
      rchk(ST, 32'h40);
      bus(E0, 1'b1, 16'h1808);
      see(1'b0, 7'h0, 4'h0, 24'h0);
      bus(C1, 1'b1, 16'h0);
      see(1'b1, 7'h0B, 4'h7, 24'h2A);
      while (isr_exit !== 1'b1) @(posedge hclk);
      rchk(ST, 32'h0);
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_ext();
      t_basic();
      t_arb();
      t_level();
      t_trap();
      t_nest();
      end_sim();
   end
endmodule // testbench

// File: vpi_arbiter.sv
// Priority selector: picks the winning pending source above the CPU level.
`timescale 1ns/1ps
`include "vpi_cfg.svh"

module vpi_arbiter (
   input  wire vpi_pkg::vpi_src_t  pending,
   input  wire vpi_pkg::vpi_prio_t prio,
   input  wire logic [3:0]         cpu_level,
   output logic                    found,
   output logic [6:0]              win_vec,
   output logic [3:0]              win_lvl
);

   // =======================================================================
   // Search from the top vector down so equal priority keeps the lowest
   // =======================================================================
   always_comb begin
      found   = 1'b0;
      win_vec = 7'h00;
      win_lvl = 4'h0;
      for (int i = `VPI_NUM_SRC - 1; i >= 0; i--) begin
         if (pending[i] && (prio[i] != 3'h0) &&
             ({1'b0, prio[i]} > cpu_level) &&
             (!found || ({1'b0, prio[i]} >= win_lvl))) begin
            found   = 1'b1;
            win_vec = 7'(i);
            win_lvl = {1'b0, prio[i]};
         end
      end
   end

endmodule // vpi_arbiter

// File: vpi_cfg.svh
// Constants of the vectored priority interrupt controller: offsets, fields, reset values.
`ifndef VPI_CFG_SVH
`define VPI_CFG_SVH

// ==========================================================================
// Sizes
// ==========================================================================
`define VPI_NUM_SRC        96
`define VPI_NUM_EXT        5
`define VPI_NUM_TRAP       4
`define VPI_NUM_BANK       6
`define VPI_NUM_IPC        24

// ==========================================================================
// Register word indices, byte address is four times the index; numbers of the absent priority registers
// ==========================================================================
`define VPI_IDX_CTRL1      6'h00
`define VPI_IDX_CTRL2      6'h01
`define VPI_IDX_FLAG0      6'h02
`define VPI_IDX_EN0        6'h08
`define VPI_IDX_PRIO0      6'h0E
`define VPI_IDX_CAPTURE    6'h26
`define VPI_IDX_STATUS     6'h27
`define VPI_IDX_CORE       6'h28
`define VPI_IPC_MISSING_A  5'h0E
`define VPI_IPC_MISSING_B  5'h11

// ==========================================================================
// Field positions
// ==========================================================================
`define VPI_NEST_BIT       15
`define VPI_TRAP_LSB       1
`define VPI_ALT_BIT        15
`define VPI_IPL_LSB        5
`define VPI_CPU_PRIORITY_MSB_BIT       3
`define VPI_RSVD_BIT       2
`define VPI_CAP_LVL_LSB    8

// ==========================================================================
// Vector numbers of the external request inputs
// ==========================================================================
`define VPI_EXT0_VEC       7'h00
`define VPI_EXT1_VEC       7'h14
`define VPI_EXT2_VEC       7'h1D
`define VPI_EXT3_VEC       7'h35
`define VPI_EXT4_VEC       7'h36

// ==========================================================================
// Vector table addresses
// ==========================================================================
`define VPI_IVT_BASE       24'h000014
`define VPI_ALT_OFFSET     24'h000100

// ==========================================================================
// Reset values
// ==========================================================================
`define VPI_RST_WORD       16'h0000
`define VPI_RST_IPL        3'h0
`define VPI_RST_BUS        32'h00000000

`endif

// File: vpi_chk.sv
// Port checker of the vectored priority interrupt controller.
`timescale 1ns/1ps
`include "vpi_cfg.svh"
// ==========================================================================
// Checker
// ==========================================================================
module vpi_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        irq_ack,
   input wire logic        irq,
   input wire logic [6:0]  irq_vector,
   input wire logic [3:0]  irq_level,
   input wire logic [23:0] irq_address
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   logic rd_go;
   assign rd_go = hsel && hready && htrans[1] && !hwrite;
   function automatic logic rd(input logic go, input logic [31:0] a, input logic [5:0] i);
      return go && (a == {24'h0, i, 2'b00});
   endfunction
   a_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
      else $error("slave answered other than ready and okay");
   a_vec_range: assert property (irq |-> irq_vector < 7'h60)
      else $error("vector beyond the last source");
   a_level_set: assert property (irq |-> irq_level inside {[1:7]})
      else $error("request raised with level zero");
   a_addr_map: assert property (irq |->
      irq_address == `VPI_IVT_BASE + {16'h0, irq_vector, 1'b0} ||
      irq_address == `VPI_IVT_BASE + `VPI_ALT_OFFSET + {16'h0, irq_vector, 1'b0})
      else $error("vector address does not match vector");
   a_ack_step: assert property (irq && irq_ack |=> !irq || irq_level > $past(irq_level))
      else $error("request kept after acknowledge without higher level");
   a_core_read: assert property (rd(rd_go, haddr, `VPI_IDX_CORE) |=>
      hrdata[31:4] == 28'h0 && hrdata[2] && hrdata[1:0] == 2'h0)
      else $error("core control read wrong fixed bits");
   a_status_read: assert property (rd(rd_go, haddr, `VPI_IDX_STATUS) |=>
      hrdata[31:8] == 24'h0 && hrdata[4:0] == 5'h0)
      else $error("status word read nonzero unused bits");
   a_capture_read: assert property (rd(rd_go, haddr, `VPI_IDX_CAPTURE) |=>
      hrdata[31:12] == 20'h0 && hrdata[7] == 1'b0)
      else $error("capture read outside its fields");
   a_ctrl1_read: assert property (rd(rd_go, haddr, `VPI_IDX_CTRL1) |=>
      hrdata[31:16] == 16'h0 && hrdata[14:5] == 10'h0 && !hrdata[0])
      else $error("control one read unused bits");
   c_irq_rise: cover property ($rose(irq));
   c_irq_taken: cover property (irq && irq_ack);
   c_cap_read: cover property (rd(rd_go, haddr, `VPI_IDX_CAPTURE));
endmodule // vpi_chk

bind vpi_ctrl vpi_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .hrdata, .irq_ack, .irq, .irq_vector, .irq_level, .irq_address);

// File: vpi_core_model.sv
// Behavioural processor core that takes requests and runs a handler.
`timescale 1ns/1ps
// ==========================================================================
// Core model
// ==========================================================================
module vpi_core_model (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       irq,
   input  wire logic       ack_en,
   input  wire logic [3:0] lag,
   input  wire logic [3:0] entry_level,
   output logic            irq_ack,
   output logic            isr_exit,
   output logic [3:0]      restore_level
);
   logic [3:0] cnt;
   logic       busy;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt           <= 4'h0;
         busy          <= 1'b0;
         irq_ack       <= 1'b0;
         isr_exit      <= 1'b0;
         restore_level <= 4'hF;
      end else begin
         irq_ack       <= 1'b0;
         isr_exit      <= 1'b0;
         restore_level <= ~entry_level;
         cnt           <= cnt + 4'h1;
         if (busy && cnt == lag) begin
            isr_exit      <= 1'b1;
            restore_level <= entry_level;
            busy          <= 1'b0;
            cnt           <= 4'h0;
         end else if (!busy && !(ack_en && irq && !irq_ack)) begin
            cnt <= 4'h0;
         end else if (!busy && cnt == lag) begin
            irq_ack <= 1'b1;
            busy    <= 1'b1;
            cnt     <= 4'h0;
         end
      end
   end
endmodule // vpi_core_model

// File: vpi_ctrl.sv
// Vectored priority interrupt controller with an AHB-Lite register slave.
`timescale 1ns/1ps
`include "vpi_cfg.svh"

module vpi_ctrl (
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic [31:0]                  hrdata,
   input  wire vpi_pkg::vpi_src_t       src_req,
   input  wire logic [`VPI_NUM_EXT-1:0]  ext_req,
   input  wire logic [`VPI_NUM_TRAP-1:0] trap_event,
   input  wire logic                    irq_ack,
   input  wire logic                    isr_exit,
   input  wire logic [3:0]              restore_level,
   output logic                         irq,
   output logic [6:0]                   irq_vector,
   output logic [3:0]                   irq_level,
   output logic [23:0]                  irq_address
);

   // =======================================================================
   // Helper functions
   // =======================================================================
   function automatic logic [6:0] ext_vec(input int unsigned k);
      logic [6:0] v;
      v = `VPI_EXT0_VEC;
      case (k)
         1: v = `VPI_EXT1_VEC;
         2: v = `VPI_EXT2_VEC;
         3: v = `VPI_EXT3_VEC;
         4: v = `VPI_EXT4_VEC;
         default: v = `VPI_EXT0_VEC;
      endcase
      return v;
   endfunction

   function automatic logic [23:0] vec_addr(input logic [6:0] vec, input logic alt);
      logic [23:0] a;
      a = `VPI_IVT_BASE + {16'h0000, vec, 1'b0};
      if (alt) begin
         a = a + `VPI_ALT_OFFSET;
      end
      return a;
   endfunction

   function automatic logic ipc_present(input logic [4:0] n);
      return (n != `VPI_IPC_MISSING_A) && (n != `VPI_IPC_MISSING_B);
   endfunction

   function automatic logic [15:0] reg_read(input vpi_pkg::vpi_state_t st,
                                            input logic [5:0] idx);
      logic [15:0] w;
      logic [5:0]  rel;
      w   = `VPI_RST_WORD;
      rel = 6'h00;
      if (idx == `VPI_IDX_CTRL1) begin
         w[`VPI_NEST_BIT] = st.nest_dis;
         w[`VPI_TRAP_LSB +: `VPI_NUM_TRAP] = st.trap;
      end else if (idx == `VPI_IDX_CTRL2) begin
         w[`VPI_ALT_BIT] = st.alt_sel;
         w[`VPI_NUM_EXT-1:0] = st.edge_pol;
      end else if ((idx >= `VPI_IDX_FLAG0) && (idx < `VPI_IDX_EN0)) begin
         rel = idx - `VPI_IDX_FLAG0;
         w   = st.flag[rel*16 +: 16];
      end else if ((idx >= `VPI_IDX_EN0) && (idx < `VPI_IDX_PRIO0)) begin
         rel = idx - `VPI_IDX_EN0;
         w   = st.enable[rel*16 +: 16];
      end else if ((idx >= `VPI_IDX_PRIO0) && (idx < `VPI_IDX_CAPTURE)) begin
         rel = idx - `VPI_IDX_PRIO0;
         if (ipc_present(rel[4:0])) begin
            for (int j = 0; j < 4; j++) begin
               w[j*4 +: 3] = st.prio[rel*4 + j];
            end
         end
      end else if (idx == `VPI_IDX_CAPTURE) begin
         w[6:0] = st.cap_vec;
         w[`VPI_CAP_LVL_LSB +: 4] = st.cap_lvl;
      end else if (idx == `VPI_IDX_STATUS) begin
         w[`VPI_IPL_LSB +: 3] = st.cpu_priority_bits;
      end else if (idx == `VPI_IDX_CORE) begin
         w[`VPI_CPU_PRIORITY_MSB_BIT] = st.cpu_priority_msb;
         w[`VPI_RSVD_BIT] = 1'b1;
      end
      return w;
   endfunction

   // =======================================================================
   // State and priority selection
   // =======================================================================
   vpi_pkg::vpi_state_t s;
   vpi_pkg::vpi_state_t next_s;
   logic                sel_found;
   logic [6:0]          sel_vec;
   logic [3:0]          sel_lvl;
   vpi_pkg::vpi_src_t   pending;
   vpi_pkg::vpi_src_t   set_req;
   logic [`VPI_NUM_EXT-1:0] ext_hit;
   logic                addr_ok;
   logic                bus_take;
   logic [5:0]          widx;
   logic [15:0]         wd;
   logic [5:0]          wrel;

   assign pending = s.flag & s.enable;

   vpi_arbiter u_arbiter (
      .pending   (pending),
      .prio      (s.prio),
      .cpu_level ({s.cpu_priority_msb, s.cpu_priority_bits}),
      .found     (sel_found),
      .win_vec   (sel_vec),
      .win_lvl   (sel_lvl)
   );

   // =======================================================================
   // Next state
   // =======================================================================
   always_comb begin
      next_s   = s;
      ext_hit  = '0;
      set_req  = src_req;
      wd       = hwdata[15:0];
      widx     = s.wr_idx;
      wrel     = 6'h00;
      addr_ok  = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
      bus_take = hsel && hready && htrans[1];

      // External request edge detection.
      for (int k = 0; k < `VPI_NUM_EXT; k++) begin
         ext_hit[k] = s.edge_pol[k] ? (s.ext_prev[k] && !ext_req[k])
                                    : (!s.ext_prev[k] && ext_req[k]);
         set_req[ext_vec(k)] = set_req[ext_vec(k)] | ext_hit[k];
      end
      next_s.ext_prev = ext_req;

      // Bus address phase.
      next_s.ready   = 1'b1;
      next_s.wr_pend = bus_take && hwrite && addr_ok;
      next_s.wr_idx  = haddr[7:2];
      if (bus_take && !hwrite) begin
         next_s.rdata = addr_ok ? {16'h0000, reg_read(s, haddr[7:2])} : `VPI_RST_BUS;
      end

      // Bus data phase write.
      if (s.wr_pend) begin
         if (widx == `VPI_IDX_CTRL1) begin
            next_s.nest_dis = wd[`VPI_NEST_BIT];
            next_s.trap     = wd[`VPI_TRAP_LSB +: `VPI_NUM_TRAP];
         end else if (widx == `VPI_IDX_CTRL2) begin
            next_s.alt_sel  = wd[`VPI_ALT_BIT];
            next_s.edge_pol = wd[`VPI_NUM_EXT-1:0];
         end else if ((widx >= `VPI_IDX_FLAG0) && (widx < `VPI_IDX_EN0)) begin
            wrel = widx - `VPI_IDX_FLAG0;
            next_s.flag[wrel*16 +: 16] = wd;
         end else if ((widx >= `VPI_IDX_EN0) && (widx < `VPI_IDX_PRIO0)) begin
            wrel = widx - `VPI_IDX_EN0;
            next_s.enable[wrel*16 +: 16] = wd;
         end else if ((widx >= `VPI_IDX_PRIO0) && (widx < `VPI_IDX_CAPTURE)) begin
            wrel = widx - `VPI_IDX_PRIO0;
            if (ipc_present(wrel[4:0])) begin
               for (int j = 0; j < 4; j++) begin
                  next_s.prio[wrel*4 + j] = wd[j*4 +: 3];
               end
            end
         end else if (widx == `VPI_IDX_STATUS) begin
            if (!s.nest_dis) begin
               next_s.cpu_priority_bits = wd[`VPI_IPL_LSB +: 3];
            end
         end else if (widx == `VPI_IDX_CORE) begin
            if (!wd[`VPI_CPU_PRIORITY_MSB_BIT]) begin
               next_s.cpu_priority_msb = 1'b0;
            end
         end
      end

      // Hardware sets win over software clears.
      next_s.flag = next_s.flag | set_req;
      next_s.trap = next_s.trap | trap_event;

      // CPU level updates from the core and from trap events.
      if (isr_exit) begin
         next_s.cpu_priority_bits    = restore_level[2:0];
         next_s.cpu_priority_msb   = restore_level[3];
         next_s.in_isr = 1'b0;
      end
      if (irq_ack && s.irq) begin
         next_s.cpu_priority_bits    = s.irq_lvl[2:0];
         next_s.cpu_priority_msb   = s.irq_lvl[3];
         next_s.in_isr = 1'b1;
      end
      if (trap_event != '0) begin
         next_s.cpu_priority_msb = 1'b1;
      end

      // Capture and request to the core.
      if (sel_found) begin
         next_s.cap_vec = sel_vec;
         next_s.cap_lvl = sel_lvl;
      end
      next_s.irq      = sel_found && !(s.nest_dis && s.in_isr);
      next_s.irq_vec  = sel_vec;
      next_s.irq_lvl  = sel_lvl;
      next_s.irq_addr = vec_addr(sel_vec, s.alt_sel);
      if (irq_ack && s.irq) begin
         next_s.irq = 1'b0;
      end
   end

   // =======================================================================
   // State register
   // =======================================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s          <= '0;
         s.ready    <= 1'b1;
         s.cpu_priority_bits      <= `VPI_RST_IPL;
         s.irq_addr <= `VPI_IVT_BASE;
      end else begin
         s <= next_s;
      end
   end

   // =======================================================================
   // Outputs
   // =======================================================================
   assign hreadyout   = s.ready;
   assign hresp       = 1'b0;
   assign hrdata      = s.rdata;
   assign irq         = s.irq;
   assign irq_vector  = s.irq_vec;
   assign irq_level   = s.irq_lvl;
   assign irq_address = s.irq_addr;

endmodule // vpi_ctrl

// File: vpi_pkg.sv
// Types of the vectored priority interrupt controller.
`include "vpi_cfg.svh"

package vpi_pkg;

   // =======================================================================
   // Per-source vectors
   // =======================================================================
   typedef logic [`VPI_NUM_SRC-1:0]      vpi_src_t;
   typedef logic [`VPI_NUM_SRC-1:0][2:0] vpi_prio_t;

   // =======================================================================
   // Whole state of the controller
   // =======================================================================
   typedef struct packed {
      logic                   nest_dis;
      logic [`VPI_NUM_TRAP-1:0] trap;
      logic                   alt_sel;
      logic [`VPI_NUM_EXT-1:0]  edge_pol;
      vpi_src_t               flag;
      vpi_src_t               enable;
      vpi_prio_t              prio;
      logic [2:0]             cpu_priority_bits;
      logic                   cpu_priority_msb;
      logic                   in_isr;
      logic [`VPI_NUM_EXT-1:0]  ext_prev;
      logic [6:0]             cap_vec;
      logic [3:0]             cap_lvl;
      logic                   wr_pend;
      logic [5:0]             wr_idx;
      logic                   ready;
      logic [31:0]            rdata;
      logic                   irq;
      logic [6:0]             irq_vec;
      logic [3:0]             irq_lvl;
      logic [23:0]            irq_addr;
   } vpi_state_t;

endpackage
